/* File: logic/irq_pkg.sv */
// constants and carrier types for the four-level interrupt controller
// How it works
// - fifteen sources, each at one of four levels
// - pins, two timers, uart rx or tx
// - eight timer requests, overflows ored together
// - capture input sets its capture flag
// - count equal compare register sets flag
// - low byte or full count overflow flags
// - hardware never clears timer event flags
// - converter done flag raises request, sticky
// - valid i2c status load sets i2c flag
// - software clears converter flag, never sets
// - software sets or clears other flags
// - per-source enable bits gate requests
// - bit 7 of primary enable is global
// - primary enable bits: adc down to ext0
// - enable, low and high priority registers
// - high,low bits give levels 0 to 3
// - equal or higher active level blocks request
// - higher request pre-empts, lower resumes later
// - timer enable: overflow, compares, captures
// - primary high priority bit 6 adc, 7 unused
package irq_pkg;
  localparam int NUM_SRC = 15;
  localparam int SRC_W = 4;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_ENABLE_PRIMARY = 8'ha8;
  localparam logic [7:0] OFS_ENABLE_TIMER = 8'he8;
  localparam logic [7:0] OFS_PRIO_LOW_PRIMARY = 8'hb8;
  localparam logic [7:0] OFS_PRIO_HIGH_PRIMARY = 8'hbc;
  localparam logic [7:0] OFS_PRIO_LOW_TIMER = 8'hf8;
  localparam logic [7:0] OFS_PRIO_HIGH_TIMER = 8'hfc;
  localparam logic [7:0] OFS_FLAGS_PRIMARY = 8'hc0;
  localparam logic [7:0] OFS_FLAGS_TIMER = 8'hc4;
  localparam logic [7:0] OFS_COMPARE_0 = 8'hd0;
  localparam logic [7:0] OFS_STATUS = 8'he0;
  localparam int GLOBAL_EN_BIT = 7;
  localparam int ADC_FLAG_BIT = 7;
  localparam int CAP_POS = 0;
  localparam int CMP_POS = 4;
  localparam int BOVF_POS = 7;
  localparam int FOVF_POS = 8;
  localparam logic [7:0] RESET_ENABLE = 8'h00;
  localparam logic [7:0] RESET_PRIO = 8'h00;
  localparam logic [15:0] RESET_COMPARE = 16'h0000;

  // one-cycle event pulses from the peripherals
  typedef struct packed {
    logic ext0;
    logic timer0;
    logic ext1;
    logic timer1;
    logic uart_rx;
    logic uart_tx;
    logic i2c_status_valid;
    logic conv_done;
    logic [3:0] capture;
    logic timer_tick;
    logic [15:0] timer_count;
  } periph_events_t;

  // request handed to the cpu core
  typedef struct packed {
    logic valid;
    logic [SRC_W-1:0] source;
    logic [1:0] level;
  } irq_grant_t;
endpackage

/* File: logic/irq_controller.sv */
// fifteen-source four-level interrupt controller with avalon-mm registers
`timescale 1ns/1ps
module irq_controller
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [irq_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire irq_pkg::periph_events_t events,
  input wire logic cpu_ack,
  input wire logic cpu_return,
  output irq_pkg::irq_grant_t grant
);
  typedef struct packed {
    logic [7:0] en_pri;
    logic [7:0] en_tmr;
    logic [7:0] pl_pri;
    logic [7:0] ph_pri;
    logic [7:0] pl_tmr;
    logic [7:0] ph_tmr;
    logic [7:0] flags_pri;
    logic [8:0] flags_tmr;
    logic [2:0][15:0] cmp;
    logic [3:0] active;
    logic wait_n;
    logic [31:0] rdata;
    irq_pkg::irq_grant_t grant;
  } state_t;

  state_t st_reg;
  state_t st_next;
  logic [irq_pkg::NUM_SRC-1:0] req;
  logic [irq_pkg::NUM_SRC-1:0] en;
  logic [irq_pkg::NUM_SRC-1:0] plo;
  logic [irq_pkg::NUM_SRC-1:0] phi;
  logic [irq_pkg::SRC_W-1:0] best_src;
  logic [1:0] best_lvl;
  logic best_any;
  logic blocked;
  logic [2:0] act_top;
  logic commit;
  logic [7:0] wd;
  logic [8:0] hw_tmr;
  logic [7:0] hw_pri;

  function automatic logic [2:0] top_active(input logic [3:0] act);
    logic [2:0] r;
    r = 3'h0;
    for (int k = 0; k < 4; k++)
    begin
      if (act[k])
      begin
        r = {1'b1, 2'(k)};
      end
    end
    return r;
  endfunction

  assign avs_readdata = st_reg.rdata;
  assign avs_waitrequest = ~st_reg.wait_n;
  assign grant = st_reg.grant;
  assign wd = avs_writedata[7:0];
  assign commit = st_reg.wait_n & (avs_read | avs_write);

  // hardware set events, one bit per flag
  always_comb
  begin
    hw_pri = {events.conv_done, events.i2c_status_valid, events.uart_tx, events.uart_rx,
              events.timer1, events.ext1, events.timer0, events.ext0};
    hw_tmr = '0;
    hw_tmr[irq_pkg::CAP_POS +: 4] = events.capture;
    for (int c = 0; c < 3; c++)
    begin
      hw_tmr[irq_pkg::CMP_POS + c] = events.timer_tick
        && events.timer_count == st_reg.cmp[c];
    end
    hw_tmr[irq_pkg::BOVF_POS] = events.timer_tick && events.timer_count[7:0] == 8'h00;
    hw_tmr[irq_pkg::FOVF_POS] = events.timer_tick && events.timer_count == 16'h0000;
  end

  // source vector: 0 ext0, 1 timer0, 2 ext1, 3 timer1, 4 uart, 5 i2c, 6 adc,
  // 7..10 captures, 11..13 compares, 14 overflow
  always_comb
  begin
    req = {st_reg.flags_tmr[irq_pkg::BOVF_POS] | st_reg.flags_tmr[irq_pkg::FOVF_POS],
           st_reg.flags_tmr[6:0],
           st_reg.flags_pri[irq_pkg::ADC_FLAG_BIT],
           st_reg.flags_pri[6],
           st_reg.flags_pri[4] | st_reg.flags_pri[5],
           st_reg.flags_pri[3:0]};
    en = {st_reg.en_tmr, st_reg.en_pri[6:0]};
    plo = {st_reg.pl_tmr, st_reg.pl_pri[6:0]};
    phi = {st_reg.ph_tmr, st_reg.ph_pri[6:0]};
  end

  // lowest index wins among equal levels, so at most one source is picked
  always_comb
  begin
    best_any = 1'b0;
    best_src = '0;
    best_lvl = 2'h0;
    for (int i = 0; i < irq_pkg::NUM_SRC; i++)
    begin
      if (req[i] && en[i] && st_reg.en_pri[irq_pkg::GLOBAL_EN_BIT])
      begin
        if (!best_any || {phi[i], plo[i]} > best_lvl)
        begin
          best_any = 1'b1;
          best_src = irq_pkg::SRC_W'(i);
          best_lvl = {phi[i], plo[i]};
        end
      end
    end
    // an active handler at the same or higher level holds the request back
    act_top = top_active(st_reg.active);
    blocked = act_top[2] && best_lvl <= act_top[1:0];
  end

  always_comb
  begin
    st_next = st_reg;
    // flags: software write first, hardware set after so a same-cycle event survives
    if (commit && avs_write)
    begin
      unique case (avs_address)
        irq_pkg::OFS_ENABLE_PRIMARY: st_next.en_pri = wd;
        irq_pkg::OFS_ENABLE_TIMER: st_next.en_tmr = wd;
        irq_pkg::OFS_PRIO_LOW_PRIMARY: st_next.pl_pri = {1'b0, wd[6:0]};
        irq_pkg::OFS_PRIO_HIGH_PRIMARY: st_next.ph_pri = {1'b0, wd[6:0]};
        irq_pkg::OFS_PRIO_LOW_TIMER: st_next.pl_tmr = wd;
        irq_pkg::OFS_PRIO_HIGH_TIMER: st_next.ph_tmr = wd;
        irq_pkg::OFS_FLAGS_PRIMARY:
        begin
          st_next.flags_pri[6:0] = wd[6:0];
          st_next.flags_pri[7] = st_reg.flags_pri[7] & wd[7];
        end
        irq_pkg::OFS_FLAGS_TIMER: st_next.flags_tmr = avs_writedata[8:0];
        irq_pkg::OFS_COMPARE_0, irq_pkg::OFS_COMPARE_0 + 8'h04,
        irq_pkg::OFS_COMPARE_0 + 8'h08:
        begin
          st_next.cmp[avs_address[3:2]] = avs_writedata[15:0];
        end
        default:
        begin
        end
      endcase
    end
    st_next.flags_pri = st_next.flags_pri | hw_pri;
    st_next.flags_tmr = st_next.flags_tmr | hw_tmr;

    // read data captured in the request cycle, shown while waitrequest is low
    st_next.rdata = '0;
    unique case (avs_address)
      irq_pkg::OFS_ENABLE_PRIMARY: st_next.rdata[7:0] = st_reg.en_pri;
      irq_pkg::OFS_ENABLE_TIMER: st_next.rdata[7:0] = st_reg.en_tmr;
      irq_pkg::OFS_PRIO_LOW_PRIMARY: st_next.rdata[7:0] = st_reg.pl_pri;
      irq_pkg::OFS_PRIO_HIGH_PRIMARY: st_next.rdata[7:0] = st_reg.ph_pri;
      irq_pkg::OFS_PRIO_LOW_TIMER: st_next.rdata[7:0] = st_reg.pl_tmr;
      irq_pkg::OFS_PRIO_HIGH_TIMER: st_next.rdata[7:0] = st_reg.ph_tmr;
      irq_pkg::OFS_FLAGS_PRIMARY: st_next.rdata[7:0] = st_reg.flags_pri;
      irq_pkg::OFS_FLAGS_TIMER: st_next.rdata[8:0] = st_reg.flags_tmr;
      irq_pkg::OFS_COMPARE_0: st_next.rdata[15:0] = st_reg.cmp[0];
      irq_pkg::OFS_COMPARE_0 + 8'h04: st_next.rdata[15:0] = st_reg.cmp[1];
      irq_pkg::OFS_COMPARE_0 + 8'h08: st_next.rdata[15:0] = st_reg.cmp[2];
      irq_pkg::OFS_STATUS:
      begin
        st_next.rdata[3:0] = st_reg.active;
        st_next.rdata[4] = st_reg.grant.valid;
        st_next.rdata[11:8] = st_reg.grant.source;
        st_next.rdata[13:12] = st_reg.grant.level;
      end
      default:
      begin
      end
    endcase
    // one wait state per access, then back to waiting
    st_next.wait_n = (avs_read | avs_write) & ~st_reg.wait_n;

    // level stack: return pops the top level, then ack pushes the granted one
    if (cpu_return)
    begin
      st_next.active[act_top[1:0]] = 1'b0;
    end
    if (cpu_ack && st_reg.grant.valid)
    begin
      st_next.active[st_reg.grant.level] = 1'b1;
    end
    st_next.grant.valid = best_any && !blocked && !cpu_ack;
    st_next.grant.source = best_src;
    st_next.grant.level = best_lvl;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.en_pri <= irq_pkg::RESET_ENABLE;
      st_reg.en_tmr <= irq_pkg::RESET_ENABLE;
      st_reg.pl_pri <= irq_pkg::RESET_PRIO;
      st_reg.ph_pri <= irq_pkg::RESET_PRIO;
      st_reg.pl_tmr <= irq_pkg::RESET_PRIO;
      st_reg.ph_tmr <= irq_pkg::RESET_PRIO;
      st_reg.cmp <= {3{irq_pkg::RESET_COMPARE}};
    end
    else
    begin
      st_reg <= st_next;
    end
  end
endmodule

/* File: test/irq_controller_monitor.sv */
// bound port checks for the interrupt controller
`timescale 1ns/1ps
module irq_controller_monitor
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [irq_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic cpu_ack,
  input wire logic cpu_return,
  input wire irq_pkg::irq_grant_t grant
);
  logic [7:0] en_reg;
  logic [3:0] act_reg;
  logic [3:0] top;
  always_comb
  begin
    top = 4'h0;
    for (int i = 0; i < 4; i++)
      if (act_reg[i])
        top = 4'h1 << i;
  end
  // shadow of the primary enable and of the active levels
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      en_reg <= 8'h00;
      act_reg <= 4'h0;
    end
    else
    begin
      if (avs_write && !avs_waitrequest && avs_address == irq_pkg::OFS_ENABLE_PRIMARY)
        en_reg <= avs_writedata[7:0];
      // return pops first, then an ack pushes, as in the same cycle on the core side
      act_reg <= (act_reg & ~(cpu_return ? top : 4'h0))
        | ((cpu_ack && grant.valid) ? (4'h1 << grant.level) : 4'h0);
    end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_src; grant.valid |-> grant.source <= 4'he; endproperty
  a_src: assert property (p_src) else $error("bad source");
  // two cycles of stable enable before judging: the grant is registered
  property p_gen; grant.valid && $stable(en_reg) && $past(en_reg, 2) == en_reg |-> en_reg[7];
  endproperty
  a_gen: assert property (p_gen) else $error("grant while global off");
  property p_en; grant.valid && grant.source < 4'h7 && $stable(en_reg)
    && $past(en_reg, 2) == en_reg |-> en_reg[grant.source]; endproperty
  a_en: assert property (p_en) else $error("grant while disabled");
  property p_lvl; grant.valid |-> (act_reg >> grant.level) == 4'h0; endproperty
  a_lvl: assert property (p_lvl) else $error("grant not above active");
  property p_drop; grant.valid && cpu_ack |=> !grant.valid; endproperty
  a_drop: assert property (p_drop) else $error("grant kept after ack");
  property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("no answer");
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer too long");
  property p_hold; grant.valid && !cpu_ack && !avs_write && !$past(avs_write) |=> grant.valid;
  endproperty
  a_hold: assert property (p_hold) else $error("request vanished");
  c_pre: cover property (cpu_ack && grant.valid && act_reg != 4'h0);
  c_ret: cover property (cpu_return && act_reg[3]);
  c_rd: cover property (avs_read && !avs_waitrequest);
endmodule
bind irq_controller irq_controller_monitor u_mon (.sys_clk(sys_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest), .cpu_ack(cpu_ack),
  .cpu_return(cpu_return), .grant(grant));

/* File: test/irq_cpu_model.sv */
// cpu core stand-in that takes grants and leaves handlers on command
`timescale 1ns/1ps
module irq_cpu_model
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire irq_pkg::irq_grant_t grant,
  input wire logic go,
  input wire logic ret,
  output logic cpu_ack,
  output logic cpu_return
);
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      cpu_ack <= 1'b0;
      cpu_return <= 1'b0;
    end
    else
    begin
      // a pulse suffices: the grant drops right after it is taken
      cpu_ack <= go && grant.valid && !cpu_ack;
      cpu_return <= ret && !cpu_return;
    end
endmodule

/* File: test/four_level_interrupt_controller_tb_top.sv */
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module four_level_interrupt_controller_tb_top;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  irq_pkg::periph_events_t events = '0;
  logic cpu_ack;
  logic cpu_return;
  irq_pkg::irq_grant_t grant;
  logic go = 1'b0;
  logic ret = 1'b0;
  logic [31:0] q;
  int err_total = 0;
  int n_compared = 0;
  irq_controller DUT (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .events(events),
    .cpu_ack(cpu_ack), .cpu_return(cpu_return), .grant(grant));
  irq_cpu_model CPU (.sys_clk(sys_clk), .rst(rst), .grant(grant), .go(go), .ret(ret),
    .cpu_ack(cpu_ack), .cpu_return(cpu_return));
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task tmo(input int n);
    if (n >= 30)
    begin
      err_total++;
      test_done;
    end
  endtask
  // one avalon access; read data land in q
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 30);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
    tmo(n);
  endtask
  task wg(input logic [3:0] s, input logic [1:0] l);
    int n;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (grant.valid !== 1'b1 && n < 30);
    tmo(n);
    `CHK(grant.source, s)
    `CHK(grant.level, l)
  endtask
  // bits: ext0 28, capture0 17, conv_done 21, tick 16, count 15:0
  task ev(input logic [28:0] e);
    events <= irq_pkg::periph_events_t'(e);
    @(posedge sys_clk);
    events <= '0;
    @(posedge sys_clk);
  endtask
  task rt;
    ret <= 1'b1;
    @(posedge sys_clk);
    ret <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task t_regs;
    bus(0, irq_pkg::OFS_ENABLE_PRIMARY, 0);
    `CHK(q[7:0], irq_pkg::RESET_ENABLE)
    bus(1, irq_pkg::OFS_PRIO_HIGH_PRIMARY, 32'hc0);
    bus(0, irq_pkg::OFS_PRIO_HIGH_PRIMARY, 0);
    `CHK(q[7:0], 8'h40)
    bus(0, 8'h10, 0);
    `CHK(q, 32'h0)
    $display("t_regs done");
  endtask
  task t_soft;
    bus(1, irq_pkg::OFS_ENABLE_PRIMARY, 32'h04);
    bus(1, irq_pkg::OFS_FLAGS_PRIMARY, 32'h04);
    repeat (4) @(posedge sys_clk);
    `CHK(grant.valid, 1'b0)
    bus(1, irq_pkg::OFS_ENABLE_PRIMARY, 32'h84);
    wg(4'h2, 2'h0);
    bus(1, irq_pkg::OFS_FLAGS_PRIMARY, 0);
    repeat (4) @(posedge sys_clk);
    `CHK(grant.valid, 1'b0)
    $display("t_soft done");
  endtask
  task t_pre;
    go <= 1'b1;
    bus(1, irq_pkg::OFS_PRIO_LOW_TIMER, 1);
    bus(1, irq_pkg::OFS_PRIO_HIGH_TIMER, 1);
    bus(1, irq_pkg::OFS_ENABLE_TIMER, 1);
    bus(1, irq_pkg::OFS_ENABLE_PRIMARY, 32'h81);
    ev(29'h10000000);
    wg(4'h0, 2'h0);
    ev(29'h0020000);
    wg(4'h7, 2'h3);
    bus(0, irq_pkg::OFS_FLAGS_TIMER, 0);
    `CHK(q[8:0], 9'h001)
    bus(1, irq_pkg::OFS_FLAGS_TIMER, 0);
    rt;
    `CHK(grant.valid, 1'b0)
    rt;
    wg(4'h0, 2'h0);
    bus(1, irq_pkg::OFS_FLAGS_PRIMARY, 0);
    go <= 1'b0;
    rt;
    $display("t_pre done");
  endtask
  task t_flags;
    bus(1, irq_pkg::OFS_FLAGS_PRIMARY, 32'h80);
    bus(0, irq_pkg::OFS_FLAGS_PRIMARY, 0);
    `CHK(q[7:0], 8'h00)
    ev(29'h0200000);
    bus(0, irq_pkg::OFS_FLAGS_PRIMARY, 0);
    `CHK(q[7:0], 8'h80)
    bus(1, irq_pkg::OFS_FLAGS_PRIMARY, 0);
    bus(0, irq_pkg::OFS_FLAGS_PRIMARY, 0);
    `CHK(q[7:0], 8'h00)
    bus(1, irq_pkg::OFS_COMPARE_0, 32'h5);
    ev(29'h0010005);
    bus(0, irq_pkg::OFS_FLAGS_TIMER, 0);
    `CHK(q[8:0], 9'h010)
    ev(29'h0010000);
    bus(0, irq_pkg::OFS_FLAGS_TIMER, 0);
    `CHK(q[8:0], 9'h1f0)
    $display("t_flags done");
  endtask
  task t_misc;
    bus(1, irq_pkg::OFS_ENABLE_PRIMARY, 32'h90);
    ev(29'h0800000);
    wg(4'h4, 2'h0);
    ev(29'h0400000);
    bus(0, irq_pkg::OFS_FLAGS_PRIMARY, 0);
    `CHK(q[7:0], 8'h60)
    bus(1, irq_pkg::OFS_FLAGS_PRIMARY, 0);
    $display("t_misc done");
  endtask
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_regs;
    t_soft;
    t_pre;
    t_flags;
    t_misc;
    test_done;
  end
endmodule
